/* File: pdc_consts.vh */
// constants for the palette dac control block
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH
// register byte addresses (vga palette ports at word offsets)
`define PDC_ADDR_MASK 8'h00
`define PDC_ADDR_RIDX 8'h04
`define PDC_ADDR_WIDX 8'h08
`define PDC_ADDR_DATA 8'h0c
`define PDC_ADDR_CTRL 8'h10
`define PDC_ADDR_STAT 8'h14
// palette control register fields
`define PDC_CTRL_MODE_LO 0
`define PDC_CTRL_MODE_HI 2
`define PDC_CTRL_DAC8 3
`define PDC_CTRL_PDOWN 4
`define PDC_CTRL_SHADOW 5
`define PDC_CTRL_RESET 8'h00
`define PDC_MASK_RESET 8'hff
// display modes
`define PDC_MODE_LUT 3'h0
`define PDC_MODE_555 3'h1
`define PDC_MODE_565 3'h2
`define PDC_MODE_888 3'h3
// lut wait cycles counted down after an access is accepted, before data or write completes
`define PDC_LUT_WAIT 2'h2
`define PDC_FIFO_DEPTH 4
`endif

/* File: pdc_fifo.v */
// small synchronous fifo for pixel words
`timescale 1ns/1ps
module pdc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire do_wr;
    wire do_rd;
    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_reg];
    assign do_wr = in_valid & in_ready;
    assign do_rd = out_valid & out_ready;
    always @(posedge sys_clk)
    begin
        if (do_wr)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
        if (!rst_n)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (do_wr && !do_rd)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (do_rd && !do_wr)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

/* File: pdc_top.v */
// palette and true-colour dac control with avalon register port
// ==========================================================
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "pdc_consts.vh"
module pdc_top (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // avalon-mm slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg avs_claimed,
    // pixel input
    input wire pix_valid,
    output reg pix_ready,
    input wire [23:0] pix_data,
    input wire pix_bypass,
    input wire pix_pointer,
    input wire [23:0] pointer_rgb,
    // converter output
    output reg dac_valid,
    input wire dac_ready,
    output reg [23:0] dac_rgb,
    output reg dac_power_on
);
    // ==========================================================
    // registers
    reg [17:0] lut [0:255];
    reg [7:0] mask_reg;
    reg [7:0] ridx_reg;
    reg [7:0] widx_reg;
    reg [1:0] comp_reg;
    reg [1:0] rcomp_reg;
    reg [5:0] red_hold_reg;
    reg [5:0] grn_hold_reg;
    reg [17:0] rd_entry_reg;
    reg [7:0] ctrl_reg;
    reg [1:0] wait_cnt_reg;
    reg busy_reg;
    reg [31:0] readdata_next;
    wire [2:0] mode;
    wire dac8;
    wire pdown;
    wire shadow;
    wire access;
    wire is_pal;
    assign mode = ctrl_reg[`PDC_CTRL_MODE_HI:`PDC_CTRL_MODE_LO];
    assign dac8 = ctrl_reg[`PDC_CTRL_DAC8];
    assign pdown = ctrl_reg[`PDC_CTRL_PDOWN];
    assign shadow = ctrl_reg[`PDC_CTRL_SHADOW];
    assign access = avs_read | avs_write;
    assign is_pal = (avs_address == `PDC_ADDR_DATA);

    // widen a six-bit component to eight bits
    function [7:0] widen6;
        input [5:0] v;
        begin
            widen6 = {v, v[5:4]};
        end
    endfunction

    // widen a five-bit component to eight bits
    function [7:0] widen5;
        input [4:0] v;
        begin
            widen5 = {v, v[4:2]};
        end
    endfunction

    // next value of the modulo-3 component counter
    function [1:0] step3;
        input [1:0] c;
        begin
            step3 = (c == 2'd2) ? 2'd0 : c + 2'd1;
        end
    endfunction

    // ==========================================================
    // register port: each access waits a fixed lut latency, then completes
    always @*
    begin
        readdata_next = 32'h0000_0000;
        case (avs_address)
            `PDC_ADDR_MASK: readdata_next = {24'h00_0000, mask_reg};
            `PDC_ADDR_RIDX: readdata_next = {24'h00_0000, ridx_reg};
            `PDC_ADDR_WIDX: readdata_next = {24'h00_0000, widx_reg};
            `PDC_ADDR_DATA:
            begin
                case (rcomp_reg)
                    2'd0: readdata_next = {26'h000_0000, rd_entry_reg[17:12]};
                    2'd1: readdata_next = {26'h000_0000, rd_entry_reg[11:6]};
                    default: readdata_next = {26'h000_0000, rd_entry_reg[5:0]};
                endcase
            end
            `PDC_ADDR_CTRL: readdata_next = {24'h00_0000, ctrl_reg};
            `PDC_ADDR_STAT: readdata_next = {28'h000_0000, 2'b00, rcomp_reg};
            default: readdata_next = 32'h0000_0000;
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            mask_reg <= `PDC_MASK_RESET;
            ridx_reg <= 8'h00;
            widx_reg <= 8'h00;
            comp_reg <= 2'd0;
            rcomp_reg <= 2'd0;
            red_hold_reg <= 6'h00;
            grn_hold_reg <= 6'h00;
            rd_entry_reg <= 18'h0_0000;
            ctrl_reg <= `PDC_CTRL_RESET;
            wait_cnt_reg <= 2'd0;
            busy_reg <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            avs_claimed <= 1'b0;
        end
        else
        begin
            avs_waitrequest <= 1'b1;
            if (access && !busy_reg && avs_waitrequest)
            begin
                busy_reg <= 1'b1;
                wait_cnt_reg <= `PDC_LUT_WAIT;
                rd_entry_reg <= lut[ridx_reg];
            end
            else if (busy_reg && wait_cnt_reg != 2'd0)
            begin
                wait_cnt_reg <= wait_cnt_reg - 2'd1;
            end
            else if (busy_reg)
            begin
                busy_reg <= 1'b0;
                avs_waitrequest <= 1'b0;
                avs_readdata <= readdata_next;
                avs_claimed <= avs_read | !(is_pal && shadow);
                if (avs_write)
                begin
                    case (avs_address)
                        `PDC_ADDR_MASK: mask_reg <= avs_writedata[7:0];
                        `PDC_ADDR_RIDX:
                        begin
                            ridx_reg <= avs_writedata[7:0];
                            rcomp_reg <= 2'd0;
                        end
                        `PDC_ADDR_WIDX:
                        begin
                            widx_reg <= avs_writedata[7:0];
                            comp_reg <= 2'd0;
                        end
                        `PDC_ADDR_DATA:
                        begin
                            comp_reg <= step3(comp_reg);
                            if (comp_reg == 2'd0)
                            begin
                                red_hold_reg <= avs_writedata[5:0];
                            end
                            else if (comp_reg == 2'd1)
                            begin
                                grn_hold_reg <= avs_writedata[5:0];
                            end
                            else
                            begin
                                widx_reg <= widx_reg + 8'h01;
                            end
                        end
                        `PDC_ADDR_CTRL: ctrl_reg <= avs_writedata[7:0];
                        default: ctrl_reg <= ctrl_reg;
                    endcase
                end
                else if (avs_read && is_pal)
                begin
                    rcomp_reg <= step3(rcomp_reg);
                    if (rcomp_reg == 2'd2)
                    begin
                        ridx_reg <= ridx_reg + 8'h01;
                    end
                end
            end
        end
    end

    // table write after blue completes an entry, data kept across power-down
    always @(posedge sys_clk)
    begin
        if (rst_n && busy_reg && wait_cnt_reg == 2'd0 && avs_write && is_pal
            && comp_reg == 2'd2)
        begin
            lut[widx_reg] <= {red_hold_reg, grn_hold_reg, avs_writedata[5:0]};
        end
    end

    // ==========================================================
    // pixel path: colour selection feeds the output fifo
    reg [23:0] pix_rgb;
    reg [17:0] lut_word;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [23:0] fifo_out_data;
    always @*
    begin
        lut_word = lut[pix_data[7:0] & mask_reg];
        pix_rgb = {widen6(lut_word[17:12]), widen6(lut_word[11:6]), widen6(lut_word[5:0])};
        if (pix_bypass || mode != `PDC_MODE_LUT)
        begin
            case (mode)
                `PDC_MODE_555: pix_rgb = {widen5(pix_data[14:10]), widen5(pix_data[9:5]),
                    widen5(pix_data[4:0])};
                `PDC_MODE_565: pix_rgb = {widen5(pix_data[15:11]), widen6(pix_data[10:5]),
                    widen5(pix_data[4:0])};
                default: pix_rgb = pix_data;
            endcase
        end
        if (pix_pointer)
        begin
            pix_rgb = pointer_rgb;
        end
        if (!dac8)
        begin
            pix_rgb = {pix_rgb[23:18], 2'b00, pix_rgb[15:10], 2'b00,
                pix_rgb[7:2], 2'b00};
        end
    end

    wire fifo_out_take;
    assign fifo_out_take = fifo_out_valid && (!dac_valid || dac_ready);

    pdc_fifo #(
        .WIDTH(24),
        .DEPTH(`PDC_FIFO_DEPTH),
        .AW(2)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(pix_valid),
        .in_ready(fifo_in_ready),
        .in_data(pix_rgb),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_take),
        .out_data(fifo_out_data)
    );

    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            dac_valid <= 1'b0;
            dac_rgb <= 24'h00_0000;
            dac_power_on <= 1'b0;
            pix_ready <= 1'b0;
        end
        else
        begin
            dac_power_on <= !pdown;
            pix_ready <= fifo_in_ready;
            if (fifo_out_take)
            begin
                dac_valid <= 1'b1;
                dac_rgb <= pdown ? 24'h00_0000 : fifo_out_data;
            end
            else if (dac_ready)
            begin
                dac_valid <= 1'b0;
            end
        end
    end
endmodule

/* File: pdc_top_chk.sv */
// assertion checker for the palette dac control block
`timescale 1ns/1ps
`include "pdc_consts.vh"
module pdc_chk (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // register bus
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire avs_waitrequest,
    input wire avs_claimed,
    // converter side
    input wire dac_valid,
    input wire dac_ready,
    input wire [23:0] dac_rgb,
    input wire dac_power_on
);
    // ====
    // control bits seen on completed writes
    reg shadow_reg;
    reg pdown_reg;
    wire req;
    wire ctrl_done;
    assign req = avs_read | avs_write;
    assign ctrl_done = avs_write && !avs_waitrequest && avs_address == `PDC_ADDR_CTRL;
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            shadow_reg <= 1'b0;
            pdown_reg <= 1'b0;
        end
        else if (ctrl_done)
        begin
            shadow_reg <= avs_writedata[`PDC_CTRL_SHADOW];
            pdown_reg <= avs_writedata[`PDC_CTRL_PDOWN];
        end
    end
    // ====
    // properties
    property p_answer_time;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(req) |-> avs_waitrequest [*4] ##1 !avs_waitrequest;
    endproperty
    a_answer_time: assert property (p_answer_time)
        else $error("access not answered after the table wait");
    property p_wait_pulse;
        @(posedge sys_clk) disable iff (!rst_n)
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse)
        else $error("waitrequest low for more than one cycle");
    property p_read_claimed;
        @(posedge sys_clk) disable iff (!rst_n)
        !avs_waitrequest && avs_read |-> avs_claimed;
    endproperty
    a_read_claimed: assert property (p_read_claimed)
        else $error("read completed without claiming the cycle");
    property p_shadow_claim;
        @(posedge sys_clk) disable iff (!rst_n)
        !avs_waitrequest && avs_write && avs_address == `PDC_ADDR_DATA
            |-> avs_claimed == !shadow_reg;
    endproperty
    a_shadow_claim: assert property (p_shadow_claim)
        else $error("palette write claim does not follow shadowing");
    property p_power_follow;
        @(posedge sys_clk) disable iff (!rst_n)
        $past(rst_n) |-> dac_power_on == !pdown_reg;
    endproperty
    a_power_follow: assert property (p_power_follow)
        else $error("converter power does not follow the control register");
    property p_pdown_blank;
        @(posedge sys_clk) disable iff (!rst_n)
        $changed(dac_rgb) && pdown_reg |-> dac_rgb == 24'h00_0000;
    endproperty
    a_pdown_blank: assert property (p_pdown_blank)
        else $error("colour sent while powered down");
    property p_dac_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        dac_valid && !dac_ready |=> dac_valid && $stable(dac_rgb);
    endproperty
    a_dac_hold: assert property (p_dac_hold)
        else $error("converter word changed before it was taken");
endmodule

/* File: pdc_sink.sv */
// converter-side sink model that answers slowly and can stall
`timescale 1ns/1ps
module pdc_sink (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // bench control
    input wire hold,
    // converter side
    output reg dac_ready
);
    reg [1:0] cnt_reg;
    always @(posedge sys_clk)
    begin
        cnt_reg <= rst_n ? cnt_reg + 2'h1 : 2'h0;
        dac_ready <= rst_n && !hold && cnt_reg != 2'h3;
    end
endmodule

/* File: tb_palette_dac_control.sv */
// testbench for the palette dac control block
`timescale 1ns/1ps
`include "pdc_consts.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) bad(n, e, g); end
module tb_palette_dac_control;
    reg sys_clk = 1'b0;
    reg rst_n;
    reg [7:0] avs_address;
    reg avs_read;
    reg avs_write;
    reg [31:0] avs_writedata;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire avs_claimed;
    reg pix_valid;
    wire pix_ready;
    reg [23:0] pix_data;
    reg pix_bypass;
    reg pix_pointer;
    reg [23:0] pointer_rgb;
    wire dac_valid;
    wire dac_ready;
    wire [23:0] dac_rgb;
    wire dac_power_on;
    reg hold;
    reg [31:0] rdata;
    reg claim;
    integer n_fail = 0;
    integer check_count = 0;
    integer cyc = 0;
    integer k;
    logic [23:0] exp_q [$];
    logic [23:0] exp_pix;
    logic [7:0] wdat [6] = '{8'hff, 8'h15, 8'h2a, 8'h01, 8'h02, 8'h03};
    logic [23:0] mpix [3] = '{24'h00_0c63, 24'h00_1863, 24'h12_3456};
    logic [23:0] mexp [3] = '{24'h18_1818, 24'h18_0c18, 24'h12_3456};
    always #25 sys_clk = ~sys_clk;
    pdc_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_claimed(avs_claimed), .pix_valid(pix_valid), .pix_ready(pix_ready),
        .pix_data(pix_data), .pix_bypass(pix_bypass), .pix_pointer(pix_pointer),
        .pointer_rgb(pointer_rgb), .dac_valid(dac_valid), .dac_ready(dac_ready),
        .dac_rgb(dac_rgb), .dac_power_on(dac_power_on));
    pdc_sink u_sink (.sys_clk(sys_clk), .rst_n(rst_n), .hold(hold), .dac_ready(dac_ready));
    // ====
    // reporting
    task bad(input string n, input logic [31:0] e, input logic [31:0] g);
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task end_of_test;
        begin
            if (n_fail == 0 && check_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            end_of_test;
        end
    end
    // ====
    // avalon master and pixel tasks
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge sys_clk);
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= wr;
            avs_read <= !wr;
            do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
            rdata = avs_readdata;
            claim = avs_claimed;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask
    task pix(input logic [23:0] d, input logic byp, input logic ptr, input logic [23:0] e);
        begin
            @(posedge sys_clk);
            while (pix_ready !== 1'b1) @(posedge sys_clk);
            pix_valid <= 1'b1;
            pix_data <= d;
            pix_bypass <= byp;
            pix_pointer <= ptr;
            exp_q.push_back(e);
            @(posedge sys_clk);
            pix_valid <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
    endtask
    task drain;
        begin
            while (exp_q.size() != 0) @(posedge sys_clk);
        end
    endtask
    always @(posedge sys_clk)
        if (rst_n && dac_valid === 1'b1 && dac_ready === 1'b1 && exp_q.size() != 0)
        begin
            exp_pix = exp_q.pop_front();
            `CHK("dac_rgb", exp_pix, dac_rgb)
        end
    // ====
    // test sequence
    initial
    begin
        rst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        {pix_valid, pix_bypass, pix_pointer, hold} = 4'h0;
        pix_data = 24'h00_0000;
        pointer_rgb = 24'h80_40c0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        bus(0, `PDC_ADDR_CTRL, 0);
        `CHK("ctrl", 32'h0000_0000, rdata)
        bus(0, `PDC_ADDR_MASK, 0);
        `CHK("mask", 32'h0000_00ff, rdata)
        bus(1, 8'h20, 32'h0000_00aa);
        bus(0, 8'h20, 0);
        `CHK("unmapped", 32'h0000_0000, rdata)
        bus(1, `PDC_ADDR_WIDX, 5);
        for (k = 0; k < 6; k++)
            bus(1, `PDC_ADDR_DATA, {24'h00_0000, wdat[k]});
        bus(1, `PDC_ADDR_RIDX, 5);
        bus(0, `PDC_ADDR_DATA, 0);
        bus(0, `PDC_ADDR_STAT, 0);
        `CHK("comp", 2'h1, rdata[1:0])
        bus(1, `PDC_ADDR_RIDX, 5);
        bus(0, `PDC_ADDR_STAT, 0);
        `CHK("comp", 2'h0, rdata[1:0])
        for (k = 0; k < 6; k++)
        begin
            bus(0, `PDC_ADDR_DATA, 0);
            `CHK("entry", wdat[k] & 8'h3f, rdata[7:0])
        end
        bus(1, `PDC_ADDR_CTRL, 32'h0000_0020);
        bus(1, `PDC_ADDR_WIDX, 7);
        for (k = 0; k < 3; k++)
        begin
            bus(1, `PDC_ADDR_DATA, 32'h0000_0011 * (k + 1));
            `CHK("claimed", 1'b0, claim)
        end
        bus(1, `PDC_ADDR_RIDX, 7);
        for (k = 0; k < 3; k++)
        begin
            bus(0, `PDC_ADDR_DATA, 0);
            `CHK("claimed", 1'b1, claim)
            `CHK("shadowed", 32'h0000_0011 * (k + 1), rdata)
        end
        bus(1, `PDC_ADDR_CTRL, 0);
        pix(24'h00_0005, 0, 0, 24'hfc_54a8);
        pix(24'h12_3456, 1, 0, 24'h10_3454);
        pix(24'h00_0005, 0, 1, 24'h80_40c0);
        pix(24'h12_3456, 1, 1, 24'h80_40c0);
        drain;
        for (k = 0; k < 3; k++)
        begin
            bus(1, `PDC_ADDR_CTRL, 32'h0000_0009 + k);
            pix(mpix[k], 0, 0, mexp[k]);
            drain;
        end
        bus(1, `PDC_ADDR_CTRL, 32'h0000_0010);
        repeat (3) @(posedge sys_clk);
        `CHK("power", 1'b0, dac_power_on)
        pix(24'h00_0005, 0, 0, 24'h00_0000);
        drain;
        bus(1, `PDC_ADDR_RIDX, 5);
        bus(0, `PDC_ADDR_DATA, 0);
        `CHK("kept", 8'h3f, rdata[7:0])
        bus(1, `PDC_ADDR_CTRL, 0);
        repeat (3) @(posedge sys_clk);
        `CHK("power", 1'b1, dac_power_on)
        hold <= 1'b1;
        for (k = 0; k < 10; k++)
            if (pix_ready === 1'b1)
                pix(24'h00_0006, 0, 0, 24'h04_080c);
        `CHK("full", 1'b0, pix_ready)
        hold <= 1'b0;
        drain;
        end_of_test;
    end
endmodule
bind pdc_top pdc_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .avs_claimed(avs_claimed),
    .dac_valid(dac_valid), .dac_ready(dac_ready), .dac_rgb(dac_rgb),
    .dac_power_on(dac_power_on));
